// [clock_calendar_unit.sv]
// Calendar time registers, alarm value registers and drift trim behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "rtc_calendar_regs.svh"
module clock_calendar_unit #(
    parameter int unsigned SEC_TICKS = `RTC_CLK_HZ
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        rtc_in,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    import rtc_calendar_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    rtc_calendar_pkg::top_s st_r;
    rtc_calendar_pkg::top_s st_nxt;

    logic [1:0]  ld_wh;
    logic [1:0]  ld_ms;
    logic        clr_half;
    logic        wr_go;
    logic [7:0]  wr_word;
    logic [7:0]  rd_word;
    logic [15:0] wr_data16;
    logic [31:0] rd_data;
    logic [1:0]  rd_resp;
    logic [15:0] wh_val;
    logic [15:0] ms_val;
    logic        sec_tick;
    logic        minute_tick;
    logic        half_sec;

    // Byte-lane merge of a 16-bit register; unassigned bits are dropped by the mask
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [15:0] din,
        input logic [1:0]  strb,
        input logic [15:0] mask
    );
        logic [15:0] m;
        m = old;
        for (int i = 0; i < 2; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return m & mask;
    endfunction

    assign wr_word   = {st_r.awaddr[7:2], 2'b00};
    assign rd_word   = {araddr[7:2], 2'b00};
    assign wr_data16 = st_r.wdata[15:0];

    rtc_prescaler #(
        .TICKS       (SEC_TICKS)
    ) u_prescaler (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .rtc_in      (rtc_in),
        .clear       (clr_half),
        .minute_tick (minute_tick),
        .cal         (st_r.cal),
        .sec_tick    (sec_tick),
        .half_sec    (half_sec)
    );

    bcd_time_counter u_time (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .sec_tick    (sec_tick),
        .ld_wh       (ld_wh),
        .ld_ms       (ld_ms),
        .wdata       (wr_data16),
        .wh_val      (wh_val),
        .ms_val      (ms_val),
        .minute_tick (minute_tick)
    );

    // Read data mux, evaluated at the address handshake
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_resp = `RESP_OKAY;
        case (rd_word)
            `OFS_WEEKDAY_HOURS: begin
                rd_data[15:0] = wh_val;
            end
            `OFS_MINUTES_SECONDS: begin
                rd_data[15:0] = ms_val;
            end
            `OFS_ALARM_MONTH_DAY: begin
                rd_data[15:0] = st_r.amd;
            end
            `OFS_ALARM_WEEKDAY_HOURS: begin
                rd_data[15:0] = st_r.awh;
            end
            `OFS_ALARM_MINUTES_SECONDS: begin
                rd_data[15:0] = st_r.ams;
            end
            `OFS_CLOCK_CONFIG_CAL: begin
                rd_data[`CAL_LSB +: 8]       = st_r.cal;
                rd_data[`HALF_SECOND_BIT]    = half_sec;
                rd_data[`WRITE_ENABLE_BIT]   = st_r.wren;
            end
            default: begin
                rd_resp = `RESP_SLVERR;
            end
        endcase
    end

    always_comb begin
        st_nxt   = st_r;
        ld_wh    = 2'h0;
        ld_ms    = 2'h0;
        clr_half = 1'b0;
        wr_go    = 1'b0;

        if (awvalid && st_r.aw_rdy) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = awaddr;
        end
        if (wvalid && st_r.w_rdy) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Commit once both halves of a write are held and the last response is gone
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            wr_go         = 1'b1;
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = `RESP_OKAY;
            case (wr_word)
                `OFS_WEEKDAY_HOURS: begin
                    if (st_r.wren) begin
                        ld_wh = st_r.wstrb[1:0];
                    end
                end
                `OFS_MINUTES_SECONDS: begin
                    if (st_r.wren) begin
                        ld_ms    = st_r.wstrb[1:0];
                        clr_half = st_r.wstrb[0];
                    end
                end
                `OFS_ALARM_MONTH_DAY: begin
                    if (st_r.wren) begin
                        st_nxt.amd = merge16(st_r.amd, wr_data16, st_r.wstrb[1:0],
                                             `MASK_MONTH_DAY);
                    end
                end
                `OFS_ALARM_WEEKDAY_HOURS: begin
                    if (st_r.wren) begin
                        st_nxt.awh = merge16(st_r.awh, wr_data16, st_r.wstrb[1:0],
                                             `MASK_WEEKDAY_HOURS);
                    end
                end
                `OFS_ALARM_MINUTES_SECONDS: begin
                    st_nxt.ams = merge16(st_r.ams, wr_data16, st_r.wstrb[1:0],
                                         `MASK_MINUTES_SECONDS);
                end
                `OFS_CLOCK_CONFIG_CAL: begin
                    // Trim byte is taken at any time; software picks a safe moment
                    if (st_r.wstrb[0]) begin
                        st_nxt.cal = st_r.wdata[`CAL_LSB +: 8];
                    end
                    if (st_r.wstrb[1]) begin
                        st_nxt.wren = st_r.wdata[`WRITE_ENABLE_BIT];
                    end
                end
                default: begin
                    st_nxt.bresp = `RESP_SLVERR;
                end
            endcase
        end

        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (arvalid && st_r.ar_rdy) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_data;
            st_nxt.rresp  = rd_resp;
        end

        st_nxt.aw_rdy = !st_nxt.aw_got;
        st_nxt.w_rdy  = !st_nxt.w_got;
        st_nxt.ar_rdy = !st_nxt.rvalid;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r      <= '0;
            st_r.amd  <= `RESET_VALUE_16;
            st_r.awh  <= `RESET_VALUE_16;
            st_r.ams  <= `RESET_VALUE_16;
            st_r.cal  <= `RESET_CAL;
            st_r.wren <= `RESET_WRITE_ENABLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign awready = st_r.aw_rdy;
    assign wready  = st_r.w_rdy;
    assign bvalid  = st_r.bvalid;
    assign bresp   = st_r.bresp;
    assign arready = st_r.ar_rdy;
    assign rvalid  = st_r.rvalid;
    assign rdata   = st_r.rdata;
    assign rresp   = st_r.rresp;

    a_alarm_lock: assert property (
        wr_go && wr_word == `OFS_ALARM_MONTH_DAY && !st_r.wren |=> $stable(st_r.amd))
        else $error("locked alarm month/day changed");
    a_time_lock: assert property (
        wr_go && wr_word == `OFS_WEEKDAY_HOURS && !st_r.wren && !sec_tick
        |=> wh_val == $past(wh_val))
        else $error("locked weekday/hours changed");
    a_wh_write: assert property (
        wr_go && wr_word == `OFS_WEEKDAY_HOURS && st_r.wren && st_r.wstrb[1:0] == 2'h3
        |=> wh_val == ($past(wr_data16) & `MASK_WEEKDAY_HOURS))
        else $error("weekday/hours write not stored");
    a_ms_write: assert property (
        wr_go && wr_word == `OFS_MINUTES_SECONDS && st_r.wren && st_r.wstrb[1:0] == 2'h3
        |=> ms_val == ($past(wr_data16) & `MASK_MINUTES_SECONDS))
        else $error("minutes/seconds write not stored");
    a_amd_write: assert property (
        wr_go && wr_word == `OFS_ALARM_MONTH_DAY && st_r.wren && st_r.wstrb[1:0] == 2'h3
        |=> st_r.amd == ($past(wr_data16) & `MASK_MONTH_DAY))
        else $error("alarm month/day write not stored");
    a_half_clear: assert property (
        wr_go && wr_word == `OFS_MINUTES_SECONDS && st_r.wren && st_r.wstrb[0]
        |=> !half_sec && ms_val[6:0] == $past(wr_data16[6:0]))
        else $error("half-second flag not cleared");
    a_read_zero: assert property (
        arvalid && arready && rd_word == `OFS_WEEKDAY_HOURS
        |=> rvalid && (rdata & ~{16'h0000, `MASK_WEEKDAY_HOURS}) == 32'h0000_0000)
        else $error("unassigned bits read non-zero");
    a_resp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

    a_awh_write: assert property (
        wr_go && wr_word == `OFS_ALARM_WEEKDAY_HOURS && st_r.wren && st_r.wstrb[1:0] == 2'h3
        |=> st_r.awh == ($past(wr_data16) & `MASK_WEEKDAY_HOURS))
        else $error("alarm weekday/hours write not stored");
    a_awh_lock: assert property (
        wr_go && wr_word == `OFS_ALARM_WEEKDAY_HOURS && !st_r.wren |=> $stable(st_r.awh))
        else $error("locked alarm weekday/hours changed");
    a_ms_lock: assert property (
        wr_go && wr_word == `OFS_MINUTES_SECONDS && !st_r.wren && !sec_tick
        |=> ms_val == $past(ms_val))
        else $error("locked minutes/seconds changed");
    a_ams_write: assert property (
        wr_go && wr_word == `OFS_ALARM_MINUTES_SECONDS && st_r.wstrb[1:0] == 2'h3
        |=> st_r.ams == ($past(wr_data16) & `MASK_MINUTES_SECONDS))
        else $error("alarm minutes/seconds write not stored");
    a_wh_partial: assert property (
        wr_go && wr_word == `OFS_WEEKDAY_HOURS && st_r.wren && st_r.wstrb[1:0] == 2'h2
        && !sec_tick
        |=> wh_val[10:8] == $past(wr_data16[10:8]) && wh_val[7:0] == $past(wh_val[7:0]))
        else $error("weekday byte write disturbed the hours");
    a_cal_write: assert property (
        wr_go && wr_word == `OFS_CLOCK_CONFIG_CAL && st_r.wstrb[0]
        |=> st_r.cal == $past(st_r.wdata[`CAL_LSB +: 8]))
        else $error("trim code write not stored");
    a_wren_write: assert property (
        wr_go && wr_word == `OFS_CLOCK_CONFIG_CAL && st_r.wstrb[1]
        |=> st_r.wren == $past(st_r.wdata[`WRITE_ENABLE_BIT]))
        else $error("write enable bit not stored");
    a_half_read: assert property (
        arvalid && arready && rd_word == `OFS_CLOCK_CONFIG_CAL
        |=> rdata[`HALF_SECOND_BIT] == $past(half_sec) && rdata[31:14] == 18'h00000)
        else $error("configuration read wrong");

    // Bus protocol checks
    a_bad_wr_resp: assert property (
        wr_go && wr_word > `OFS_CLOCK_CONFIG_CAL |=> bvalid && bresp == `RESP_SLVERR)
        else $error("unmapped write not refused");
    a_bad_rd_resp: assert property (
        arvalid && arready && rd_word > `OFS_CLOCK_CONFIG_CAL
        |=> rvalid && rresp == `RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_rdata_hold: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped early");
    a_bvalid_after: assert property (
        wr_go |=> bvalid)
        else $error("write response missing after commit");
    a_one_write: assert property (
        st_r.aw_got && st_r.bvalid |=> !awready)
        else $error("second write address taken while one is pending");
    a_write_ready: assert property (
        st_r.w_got |-> !wready)
        else $error("second write data taken while one is held");

    c_wh_write: cover property (wr_go && wr_word == `OFS_WEEKDAY_HOURS && st_r.wren);
    c_locked: cover property (wr_go && !st_r.wren && wr_word == `OFS_ALARM_MONTH_DAY);
    c_minute: cover property (minute_tick && st_r.cal != 8'h00);
    c_cfg_read: cover property (arvalid && arready && rd_word == `OFS_CLOCK_CONFIG_CAL);
    c_slverr: cover property (bvalid && bresp == `RESP_SLVERR);
endmodule // clock_calendar_unit
`default_nettype wire

// [rtc_calendar_regs.svh]
// Register offsets, field positions, reset values and timing counts of the calendar block
`ifndef RTC_CALENDAR_REGS_SVH
`define RTC_CALENDAR_REGS_SVH

`define OFS_WEEKDAY_HOURS          8'h00
`define OFS_MINUTES_SECONDS        8'h04
`define OFS_ALARM_MONTH_DAY        8'h08
`define OFS_ALARM_WEEKDAY_HOURS    8'h0C
`define OFS_ALARM_MINUTES_SECONDS  8'h10
`define OFS_CLOCK_CONFIG_CAL       8'h14

`define MASK_WEEKDAY_HOURS         16'h073F
`define MASK_MINUTES_SECONDS       16'h7F7F
`define MASK_MONTH_DAY             16'h1F3F

`define WEEKDAY_LSB                8
`define HOUR_TENS_LSB              4
`define HOUR_ONES_LSB              0
`define MINUTE_TENS_LSB            12
`define MINUTE_ONES_LSB            8
`define SECOND_TENS_LSB            4
`define SECOND_ONES_LSB            0
`define MONTH_TENS_LSB             12
`define MONTH_ONES_LSB             8
`define DAY_TENS_LSB               4
`define DAY_ONES_LSB               0

`define CAL_LSB                    0
`define HALF_SECOND_BIT            11
`define WRITE_ENABLE_BIT           13

`define RESET_VALUE_16             16'h0000
`define RESET_CAL                  8'h00
`define RESET_WRITE_ENABLE         1'b0

`define WEEKDAY_LAST               3'h6
`define BCD_LAST_DIGIT             4'h9
`define TENS_LAST_SIXTY            3'h5
`define HOUR_TENS_LAST             2'h2
`define HOUR_ONES_LAST_DAY         4'h3

`define RTC_CLK_HZ                 32768
`define CAL_STEP_ZEROS             2'b00

`define RESP_OKAY                  2'h0
`define RESP_SLVERR                2'h2

`endif

// [rtc_calendar_pkg.sv]
// State types shared by the calendar block modules
`default_nettype none
package rtc_calendar_pkg;

    typedef struct packed {
        logic        rtc_q;
        logic [15:0] cnt;
        logic [10:0] adj;
        logic        sec;
    } tick_s;

    typedef struct packed {
        logic [2:0] weekday;
        logic [1:0] hour_tens;
        logic [3:0] hour_ones;
        logic [2:0] minute_tens;
        logic [3:0] minute_ones;
        logic [2:0] second_tens;
        logic [3:0] second_ones;
        logic       min_pulse;
    } bcd_s;

    typedef struct packed {
        logic        aw_rdy;
        logic        w_rdy;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        ar_rdy;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [15:0] amd;
        logic [15:0] awh;
        logic [15:0] ams;
        logic [7:0]  cal;
        logic        wren;
    } top_s;

endpackage
`default_nettype wire

// [rtc_prescaler.sv]
// Divides the 32.768 kHz input to seconds and applies the per-minute drift trim
`timescale 1ns/1ps
`default_nettype none
`include "rtc_calendar_regs.svh"
module rtc_prescaler #(
    parameter int unsigned TICKS = `RTC_CLK_HZ
) (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       rtc_in,
    input  wire logic       clear,
    input  wire logic       minute_tick,
    input  wire logic [7:0] cal,
    output logic            sec_tick,
    output logic            half_sec
);
    import rtc_calendar_pkg::*;

    localparam logic [16:0] TICKS_W = 17'(TICKS);
    localparam logic [15:0] HALF_W  = 16'(TICKS / 2);

    tick_s       st_r;
    tick_s       st_nxt;
    logic        rise;
    logic [1:0]  step;
    logic [16:0] sum;

    assign rise = rtc_in && !st_r.rtc_q;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sec = 1'b0;
        st_nxt.rtc_q = rtc_in;
        step = 2'h0;
        if (rise) begin
            if ($signed(st_r.adj) > 0) begin
                step = 2'h2;
                st_nxt.adj = st_r.adj - 11'h001;
            end else if ($signed(st_r.adj) < 0) begin
                step = 2'h0;
                st_nxt.adj = st_r.adj + 11'h001;
            end else begin
                step = 2'h1;
            end
        end
        sum = {1'b0, st_r.cnt} + {15'h0000, step};
        if (sum >= TICKS_W) begin
            st_nxt.cnt = 16'(sum - TICKS_W);
            st_nxt.sec = 1'b1;
        end else begin
            st_nxt.cnt = sum[15:0];
        end
        // Trim amount is four pulses per code step, loaded once a minute
        if (minute_tick) begin
            st_nxt.adj = {cal[7], cal, `CAL_STEP_ZEROS};
        end
        if (clear) begin
            st_nxt.cnt = 16'h0000;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sec_tick = st_r.sec;
    assign half_sec = st_r.cnt >= HALF_W;

    a_cal_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        minute_tick |=> $signed(st_r.adj) == 4 * $signed($past(cal)))
        else $error("trim amount not four times the code");
    a_cal_add: assert property (@(posedge ref_clk) disable iff (!rstn)
        rise && $signed(st_r.adj) > 0 && !minute_tick |=> st_r.adj == $past(st_r.adj) - 11'h001)
        else $error("positive trim not consumed");
    a_cal_swallow: assert property (@(posedge ref_clk) disable iff (!rstn)
        rise && $signed(st_r.adj) < 0 && !clear |=> st_r.cnt == $past(st_r.cnt))
        else $error("negative trim did not drop a pulse");
endmodule // rtc_prescaler
`default_nettype wire

// [bcd_time_counter.sv]
// BCD weekday, hours, minutes and seconds with decimal carries and software load
`timescale 1ns/1ps
`default_nettype none
`include "rtc_calendar_regs.svh"
module bcd_time_counter (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        sec_tick,
    input  wire logic [1:0]  ld_wh,
    input  wire logic [1:0]  ld_ms,
    input  wire logic [15:0] wdata,
    output logic [15:0]      wh_val,
    output logic [15:0]      ms_val,
    output logic             minute_tick
);
    import rtc_calendar_pkg::*;

    bcd_s st_r;
    bcd_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.min_pulse = 1'b0;
        if (sec_tick) begin
            if (st_r.second_ones != `BCD_LAST_DIGIT) begin
                st_nxt.second_ones = st_r.second_ones + 4'h1;
            end else begin
                st_nxt.second_ones = 4'h0;
                if (st_r.second_tens != `TENS_LAST_SIXTY) begin
                    st_nxt.second_tens = st_r.second_tens + 3'h1;
                end else begin
                    st_nxt.second_tens = 3'h0;
                    st_nxt.min_pulse = 1'b1;
                    if (st_r.minute_ones != `BCD_LAST_DIGIT) begin
                        st_nxt.minute_ones = st_r.minute_ones + 4'h1;
                    end else begin
                        st_nxt.minute_ones = 4'h0;
                        if (st_r.minute_tens != `TENS_LAST_SIXTY) begin
                            st_nxt.minute_tens = st_r.minute_tens + 3'h1;
                        end else begin
                            st_nxt.minute_tens = 3'h0;
                            if (st_r.hour_tens == `HOUR_TENS_LAST
                                && st_r.hour_ones == `HOUR_ONES_LAST_DAY) begin
                                st_nxt.hour_tens = 2'h0;
                                st_nxt.hour_ones = 4'h0;
                                st_nxt.weekday = (st_r.weekday >= `WEEKDAY_LAST)
                                    ? 3'h0 : st_r.weekday + 3'h1;
                            end else if (st_r.hour_ones == `BCD_LAST_DIGIT) begin
                                st_nxt.hour_ones = 4'h0;
                                st_nxt.hour_tens = st_r.hour_tens + 2'h1;
                            end else begin
                                st_nxt.hour_ones = st_r.hour_ones + 4'h1;
                            end
                        end
                    end
                end
            end
        end
        if (ld_wh[1]) begin
            st_nxt.weekday = wdata[`WEEKDAY_LSB +: 3];
        end
        if (ld_wh[0]) begin
            st_nxt.hour_tens = wdata[`HOUR_TENS_LSB +: 2];
            st_nxt.hour_ones = wdata[`HOUR_ONES_LSB +: 4];
        end
        if (ld_ms[1]) begin
            st_nxt.minute_tens = wdata[`MINUTE_TENS_LSB +: 3];
            st_nxt.minute_ones = wdata[`MINUTE_ONES_LSB +: 4];
        end
        if (ld_ms[0]) begin
            st_nxt.second_tens = wdata[`SECOND_TENS_LSB +: 3];
            st_nxt.second_ones = wdata[`SECOND_ONES_LSB +: 4];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wh_val = {5'h00, st_r.weekday, 2'h0, st_r.hour_tens, st_r.hour_ones};
    assign ms_val = {1'b0, st_r.minute_tens, st_r.minute_ones,
                     1'b0, st_r.second_tens, st_r.second_ones};
    assign minute_tick = st_r.min_pulse;

    a_sec_roll: assert property (@(posedge ref_clk) disable iff (!rstn)
        sec_tick && ms_val[7:0] == 8'h59 && ld_ms == 2'h0
        |=> ms_val[7:0] == 8'h00 && minute_tick)
        else $error("seconds did not roll into minutes");
    a_day_roll: assert property (@(posedge ref_clk) disable iff (!rstn)
        sec_tick && ms_val == 16'h5959 && wh_val[7:0] == 8'h23 && ld_wh == 2'h0
        && ld_ms == 2'h0
        |=> wh_val[7:0] == 8'h00
            && wh_val[10:8] == (($past(wh_val[10:8]) >= 3'h6) ? 3'h0 : $past(wh_val[10:8]) + 3'h1))
        else $error("hours did not roll into weekday");
endmodule // bcd_time_counter
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the calendar time registers and drift trim
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk = 0, rstn = 0, rtc_in = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 0;
    logic [1:0]  bresp, rresp;
    int          n_fail = 0, n_checks = 0, k;
    // Address, write value, expected read-back
    logic [39:0] rows [8] = '{{8'h14, 16'h2000, 16'h2000}, {8'h00, 16'hFFFF, 16'h073F},
        {8'h04, 16'hFFFF, 16'h7F7F}, {8'h08, 16'hFFFF, 16'h1F3F}, {8'h0C, 16'hFFFF, 16'h073F},
        {8'h10, 16'hFFFF, 16'h7F7F}, {8'h00, 16'h0623, 16'h0623}, {8'h04, 16'h5959, 16'h5959}};
    // Trim code and pulses needed for one second after a minute boundary
    logic [7:0]  codes [4] = '{8'h01, 8'hFF, 8'h80, 8'h00};
    int          pulses [4] = '{4, 12, 520, 8};

    clock_calendar_unit #(.SEC_TICKS(8)) clock_calendar_unit_i (.ref_clk, .rstn, .rtc_in,
        .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready);

    initial forever #25 ref_clk = ~ref_clk;

    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s,
                      input logic [1:0] er);
        int i;
        i = 0;
        awaddr <= a; wdata <= {16'h0000, d}; wstrb <= {2'h0, s};
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            i++;
        end while (!bvalid && i < 50);
        if (i >= 50) begin n_fail++; end_sim(); end
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
        int i;
        i = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            i++;
        end while (!rvalid && i < 50);
        if (i >= 50) begin n_fail++; end_sim(); end
        chk(rdata, {16'h0000, e});
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            rtc_in <= 1'b1;
            repeat (3) @(posedge ref_clk);
            rtc_in <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        for (k = 0; k < 6; k++) rd(8'(k * 4), 16'h0000, 2'h0);
        foreach (rows[j]) begin
            wr(rows[j][39:32], rows[j][31:16], 2'h3, 2'h0);
            rd(rows[j][39:32], rows[j][15:0], 2'h0);
        end
        tick(8);
        rd(8'h00, 16'h0000, 2'h0);
        rd(8'h04, 16'h0000, 2'h0);
        wr(8'h14, 16'h0000, 2'h3, 2'h0);
        wr(8'h00, 16'h0111, 2'h3, 2'h0);
        rd(8'h00, 16'h0000, 2'h0);
        wr(8'h04, 16'h0111, 2'h3, 2'h0);
        rd(8'h04, 16'h0000, 2'h0);
        wr(8'h08, 16'h0111, 2'h3, 2'h0);
        rd(8'h08, 16'h1F3F, 2'h0);
        wr(8'h0C, 16'h0111, 2'h3, 2'h0);
        rd(8'h0C, 16'h073F, 2'h0);
        wr(8'h10, 16'h0102, 2'h3, 2'h0);
        rd(8'h10, 16'h0102, 2'h0);
        wr(8'h18, 16'h1234, 2'h3, 2'h2);
        rd(8'h18, 16'h0000, 2'h2);
        foreach (codes[j]) begin
            wr(8'h14, {8'h20, codes[j]}, 2'h3, 2'h0);
            wr(8'h04, 16'h0059, 2'h3, 2'h0);
            tick(8);
            tick(pulses[j]);
            rd(8'h04, 16'h0101, 2'h0);
        end
        tick(4);
        rd(8'h14, 16'h2800, 2'h0);
        wr(8'h04, 16'h0000, 2'h1, 2'h0);
        rd(8'h14, 16'h2000, 2'h0);
        rd(8'h04, 16'h0100, 2'h0);
        wr(8'h00, 16'h0415, 2'h2, 2'h0);
        rd(8'h00, 16'h0400, 2'h0);
        // Reset in mid-run must bring back the locked, zeroed state
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rd(8'h14, 16'h0000, 2'h0);
        rd(8'h10, 16'h0000, 2'h0);
        wr(8'h00, 16'h0111, 2'h3, 2'h0);
        rd(8'h00, 16'h0000, 2'h0);
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
